// ==== core/csu_pkg.sv ====
// package of constants and types for the compare, shift and subtract unit
`default_nettype none
package csu_pkg;
  // ---------------------------------------------------------------------------
  // instruction field positions
  // ---------------------------------------------------------------------------
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int FSRC_MSB = 25;
  localparam int FSRC_LSB = 21;
  localparam int SSRC_MSB = 20;
  localparam int SSRC_LSB = 16;
  localparam int DST_MSB = 15;
  localparam int DST_LSB = 11;
  localparam int SHAMT_MSB = 10;
  localparam int SHAMT_LSB = 6;
  localparam int FUNC_MSB = 5;
  localparam int FUNC_LSB = 0;
  localparam int IMM_MSB = 15;

  // ---------------------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------------------
  localparam logic [5:0] OPC_REGFMT = 6'h00;
  localparam logic [5:0] OPC_LESS_SIMM = 6'h0a;
  localparam logic [5:0] OPC_LESS_UIMM = 6'h0b;
  localparam logic [5:0] FN_SHR_LOGIC_FIX = 6'h02;
  localparam logic [5:0] FN_SHR_ARITH_FIX = 6'h03;
  localparam logic [5:0] FN_SHR_LOGIC_VAR = 6'h06;
  localparam logic [5:0] FN_SHR_ARITH_VAR = 6'h07;
  localparam logic [5:0] FN_SUB = 6'h22;
  localparam logic [5:0] FN_SUBNT = 6'h23;
  localparam logic [5:0] FN_LESS_SREG = 6'h2a;
  localparam logic [5:0] FN_LESS_UREG = 6'h2b;
  localparam logic [4:0] SHAMT_ZERO = 5'h00;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [63:0] RESULT_RST = 64'h0;
  localparam logic [4:0] DEST_RST = 5'h00;

  // operation selected by the decoder
  typedef enum logic [8:0] {
    CSU_OP_NONE = 9'h001,
    CSU_OP_LESS_SREG = 9'h002,
    CSU_OP_LESS_UREG = 9'h004,
    CSU_OP_LESS_SIMM = 9'h008,
    CSU_OP_LESS_UIMM = 9'h010,
    CSU_OP_SHR = 9'h020,
    CSU_OP_SUB = 9'h040,
    CSU_OP_SUBNT = 9'h080,
    CSU_OP_ILL = 9'h100
  } csu_op_t;

  // request from the decoder: instruction word and register operands
  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [63:0] srcA;
    logic [63:0] srcB;
  } csu_req_t;

  // answer to the register file
  typedef struct packed {
    logic wrEn;
    logic [4:0] wrAddr;
    logic [63:0] wrData;
    logic ovfTrap;
    logic done;
  } csu_rsp_t;
endpackage : csu_pkg
`default_nettype wire

// ==== core/csu_shifter.sv ====
// right shifter for the low word with sign extension of the 32-bit result
`default_nettype none
module csu_shifter (
  input wire logic [63:0] operand, // source register value
  input wire logic [4:0] amount, // shift distance
  input wire logic arith, // 1: fill with bit 31, 0: fill with zeros
  output logic [63:0] result // sign-extended 32-bit result
);
  logic [31:0] word;
  // --------------------------------------------------------------------------
  // shift datapath
  // --------------------------------------------------------------------------
  // only the low word takes part; upper half of the operand is ignored
  always_comb begin
    word = arith ? 32'($signed(operand[31:0]) >>> amount) : (operand[31:0] >> amount);
    result = {{32{word[31]}}, word};
  end
endmodule : csu_shifter
`default_nettype wire

// ==== core/csu_unit.sv ====
// compare, shift and subtract execution slice of a 64-bit integer core
//
// Summary of operation
// - signed register compare writes 1 if first < second, else 0, zero-extended.
// - immediate compares sign-extend the 16-bit immediate and never trap.
// - unsigned register compare writes 1 if first < second unsigned; no trap.
// - unsigned register compare decodes as opcode 0, shift 0, function 101011.
// - fixed arithmetic right shift, function 000011, fills with bit 31.
// - fixed logical right shift, function 000010, fills with zeros.
// - variable right shifts use only the low five bits of first source.
// - right shifts use the low word and sign-extend the result from bit 31.
// - trapping subtract, function 100010, writes first minus second.
// - overflow trap exactly when carries out of bits 30 and 31 differ.
// - on overflow trap the destination write is suppressed.
// - non-trapping subtract gives the same result but never traps.
`default_nettype none
module csu_unit #(
  parameter int XLEN = 64, // register width
  parameter int WORD_BITS = 32 // low word used by shifts and subtracts
) (
  input wire logic core_clk, // core clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire csu_pkg::csu_req_t req, // instruction and operands, one cycle
  output csu_pkg::csu_rsp_t rsp // registered answer, one cycle later
);
  // ---------------------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------------------
  // the datapath is built for 64-bit registers holding 32-bit words only
  if (XLEN != 64 || WORD_BITS != 32) begin : g_width_check
    $error("unsupported register or word width");
  end

  // ---------------------------------------------------------------------------
  // field extraction
  // ---------------------------------------------------------------------------
  logic [5:0] opcode;
  logic [4:0] fsrcIdx;
  logic [4:0] ssrcIdx;
  logic [4:0] dstIdx;
  logic [4:0] shamt;
  logic [5:0] func;
  logic [63:0] immExt;
  // fixed bit positions of the register format
  assign opcode = req.instr[csu_pkg::OPC_MSB:csu_pkg::OPC_LSB];
  assign fsrcIdx = req.instr[csu_pkg::FSRC_MSB:csu_pkg::FSRC_LSB];
  assign ssrcIdx = req.instr[csu_pkg::SSRC_MSB:csu_pkg::SSRC_LSB];
  assign dstIdx = req.instr[csu_pkg::DST_MSB:csu_pkg::DST_LSB];
  assign shamt = req.instr[csu_pkg::SHAMT_MSB:csu_pkg::SHAMT_LSB];
  assign func = req.instr[csu_pkg::FUNC_MSB:csu_pkg::FUNC_LSB];
  // immediate widened by copying bit 15
  assign immExt = {{48{req.instr[csu_pkg::IMM_MSB]}}, req.instr[15:0]};

  // ---------------------------------------------------------------------------
  // decoder
  // ---------------------------------------------------------------------------
  csu_pkg::csu_op_t op;
  logic shArith;
  logic shVar;
  // unknown encodings become CSU_OP_ILL and write nothing
  always_comb begin
    op = csu_pkg::CSU_OP_NONE;
    shArith = 1'b0;
    shVar = 1'b0;
    if (!req.valid) begin
      op = csu_pkg::CSU_OP_NONE;
    end else if (opcode == csu_pkg::OPC_LESS_SIMM) begin
      op = csu_pkg::CSU_OP_LESS_SIMM;
    end else if (opcode == csu_pkg::OPC_LESS_UIMM) begin
      op = csu_pkg::CSU_OP_LESS_UIMM;
    end else if (opcode != csu_pkg::OPC_REGFMT) begin
      op = csu_pkg::CSU_OP_ILL;
    end else if (func == csu_pkg::FN_LESS_UREG && shamt == csu_pkg::SHAMT_ZERO) begin
      op = csu_pkg::CSU_OP_LESS_UREG;
    end else if (func == csu_pkg::FN_LESS_SREG) begin
      op = csu_pkg::CSU_OP_LESS_SREG;
    end else if (func == csu_pkg::FN_SHR_ARITH_FIX || func == csu_pkg::FN_SHR_LOGIC_FIX) begin
      op = csu_pkg::CSU_OP_SHR;
      shArith = (func == csu_pkg::FN_SHR_ARITH_FIX);
    end else if (func == csu_pkg::FN_SHR_ARITH_VAR || func == csu_pkg::FN_SHR_LOGIC_VAR) begin
      op = csu_pkg::CSU_OP_SHR;
      shArith = (func == csu_pkg::FN_SHR_ARITH_VAR);
      shVar = 1'b1;
    end else if (func == csu_pkg::FN_SUB) begin
      op = csu_pkg::CSU_OP_SUB;
    end else if (func == csu_pkg::FN_SUBNT) begin
      op = csu_pkg::CSU_OP_SUBNT;
    end else begin
      op = csu_pkg::CSU_OP_ILL;
    end
  end

  // ---------------------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------------------
  logic [4:0] shDist;
  logic [63:0] shResult;
  // variable shifts look only at five low bits of the first source
  assign shDist = shVar ? req.srcA[4:0] : shamt;

  csu_shifter u_shifter (
    .operand(req.srcB),
    .amount(shDist),
    .arith(shArith),
    .result(shResult)
  );

  logic [31:0] diffWord;
  logic carry30;
  logic carry31;
  logic subOvf;
  logic signedLess;
  logic unsignedLess;
  logic [63:0] cmpRhs;
  // carries taken from a 31-bit and a 32-bit add of a + ~b + 1
  always_comb begin
    logic [31:0] low31;
    logic [32:0] full32;
    low31 = {1'b0, req.srcA[30:0]} + {1'b0, ~req.srcB[30:0]} + 32'h1;
    full32 = {1'b0, req.srcA[31:0]} + {1'b0, ~req.srcB[31:0]} + 33'h1;
    carry30 = low31[31];
    carry31 = full32[32];
    diffWord = full32[31:0];
    subOvf = carry30 ^ carry31;
  end
  // compares use full 64-bit magnitude; no overflow path is involved
  always_comb begin
    cmpRhs = (op == csu_pkg::CSU_OP_LESS_SIMM || op == csu_pkg::CSU_OP_LESS_UIMM) ? immExt :
      req.srcB;
    signedLess = $signed(req.srcA) < $signed(cmpRhs);
    unsignedLess = req.srcA < cmpRhs;
  end

  // ---------------------------------------------------------------------------
  // result register
  // ---------------------------------------------------------------------------
  csu_pkg::csu_rsp_t rsp_reg;
  csu_pkg::csu_rsp_t rsp_next;
  // only a trapping subtract may raise the overflow flag
  always_comb begin
    rsp_next = '0;
    rsp_next.wrAddr = dstIdx;
    rsp_next.done = req.valid;
    case (op)
      csu_pkg::CSU_OP_LESS_SREG: begin
        rsp_next.wrEn = 1'b1;
        rsp_next.wrData = {63'h0, signedLess};
      end
      csu_pkg::CSU_OP_LESS_UREG: begin
        rsp_next.wrEn = 1'b1;
        rsp_next.wrData = {63'h0, unsignedLess};
      end
      csu_pkg::CSU_OP_LESS_SIMM: begin
        rsp_next.wrEn = 1'b1;
        rsp_next.wrAddr = ssrcIdx; // immediate form targets second field
        rsp_next.wrData = {63'h0, signedLess};
      end
      csu_pkg::CSU_OP_LESS_UIMM: begin
        rsp_next.wrEn = 1'b1;
        rsp_next.wrAddr = ssrcIdx;
        rsp_next.wrData = {63'h0, unsignedLess};
      end
      csu_pkg::CSU_OP_SHR: begin
        rsp_next.wrEn = 1'b1;
        rsp_next.wrData = shResult;
      end
      csu_pkg::CSU_OP_SUB: begin
        rsp_next.wrEn = !subOvf;
        rsp_next.ovfTrap = subOvf;
        rsp_next.wrData = {{32{diffWord[31]}}, diffWord};
      end
      csu_pkg::CSU_OP_SUBNT: begin
        rsp_next.wrEn = 1'b1;
        rsp_next.wrData = {{32{diffWord[31]}}, diffWord};
      end
      default: begin
        rsp_next.wrEn = 1'b0;
      end
    endcase
  end

  // registered so every output comes from a flip-flop
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end
  assign rsp = rsp_reg;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence subReq;
    op == csu_pkg::CSU_OP_SUB;
  endsequence
  sequence ovfSeen;
    subOvf;
  endsequence
  // any right shift, fixed or variable
  sequence shiftReq;
    op == csu_pkg::CSU_OP_SHR;
  endsequence

  less_sreg_a: assert property (op == csu_pkg::CSU_OP_LESS_SREG |=> rsp.wrEn &&
    rsp.wrData == {63'h0, $past(signedLess)})
    else $error("signed compare result wrong");
  less_simm_a: assert property (op == csu_pkg::CSU_OP_LESS_SIMM |=> rsp.wrAddr ==
    $past(ssrcIdx) && rsp.wrData[63:1] == 63'h0)
    else $error("signed immediate compare target wrong");
  imm_notrap_a: assert property ((op == csu_pkg::CSU_OP_LESS_SIMM ||
    op == csu_pkg::CSU_OP_LESS_UIMM) |=> !rsp.ovfTrap && rsp.wrEn)
    else $error("immediate compare trapped");
  less_uimm_a: assert property (op == csu_pkg::CSU_OP_LESS_UIMM |=> rsp.wrData[0] ==
    ($past(req.srcA) < $past(immExt)))
    else $error("unsigned immediate compare wrong");
  less_ureg_a: assert property (op == csu_pkg::CSU_OP_LESS_UREG |=> !rsp.ovfTrap &&
    rsp.wrData == {63'h0, $past(req.srcA) < $past(req.srcB)})
    else $error("unsigned compare wrong");
  ureg_decode_a: assert property (req.valid && opcode == 6'h00 && func == 6'h2b &&
    shamt == 5'h00 |-> op == csu_pkg::CSU_OP_LESS_UREG)
    else $error("unsigned compare not decoded");
  arith_fill_a: assert property (shiftReq ##0 shArith && !shVar |=>
    rsp.wrData[31:0] == 32'($signed($past(req.srcB[31:0])) >>> $past(shamt)))
    else $error("arithmetic shift wrong");
  logic_fill_a: assert property (shiftReq ##0 !shArith && !shVar |=>
    rsp.wrData[31:0] == ($past(req.srcB[31:0]) >> $past(shamt)))
    else $error("logical shift wrong");
  var_arith_a: assert property (shiftReq ##0 shArith && shVar |=>
    rsp.wrData[31:0] == 32'($signed($past(req.srcB[31:0])) >>> $past(req.srcA[4:0])))
    else $error("variable arithmetic shift wrong");
  shift_notrap_a: assert property (shiftReq |=> rsp.wrEn && !rsp.ovfTrap)
    else $error("shift trapped");
  sub_sext_a: assert property (subReq |=> rsp.wrData[63:32] == {32{rsp.wrData[31]}})
    else $error("difference not sign-extended");
  subnt_value_a: assert property (op == csu_pkg::CSU_OP_SUBNT |=>
    rsp.wrData[31:0] == 32'($past(req.srcA[31:0]) - $past(req.srcB[31:0])))
    else $error("non-trapping difference wrong");
  dest_field_a: assert property ((op == csu_pkg::CSU_OP_LESS_SREG ||
    op == csu_pkg::CSU_OP_SHR || op == csu_pkg::CSU_OP_SUBNT) |=> rsp.wrAddr ==
    $past(req.instr[15:11]))
    else $error("destination field wrong");
  cmp_zext_a: assert property ((op == csu_pkg::CSU_OP_LESS_SREG ||
    op == csu_pkg::CSU_OP_LESS_UREG) |=> rsp.wrData[63:1] == 63'h0)
    else $error("compare result not zero-extended");
  ill_silent_a: assert property (op == csu_pkg::CSU_OP_ILL |=> rsp.done &&
    !rsp.wrEn && !rsp.ovfTrap)
    else $error("refused encoding wrote or trapped");
  var_amount_a: assert property (shVar |-> shDist == req.srcA[4:0])
    else $error("variable shift distance wrong");
  shift_sext_a: assert property (op == csu_pkg::CSU_OP_SHR |=>
    rsp.wrData[63:32] == {32{rsp.wrData[31]}})
    else $error("shift result not sign-extended");
  sub_write_a: assert property (subReq ##0 !subOvf |=> rsp.wrEn &&
    rsp.wrData[31:0] == 32'($past(req.srcA[31:0]) - $past(req.srcB[31:0])))
    else $error("subtract result wrong");
  sub_ovf_a: assert property (subReq |=> rsp.ovfTrap ==
    ($past(req.srcA[31]) != $past(req.srcB[31]) && $past(diffWord[31]) != $past(req.srcA[31])))
    else $error("overflow flag wrong");
  ovf_nowrite_a: assert property (subReq ##0 ovfSeen |=> !rsp.wrEn)
    else $error("write not suppressed on overflow");
  subnt_notrap_a: assert property (op == csu_pkg::CSU_OP_SUBNT |=> rsp.wrEn && !rsp.ovfTrap)
    else $error("non-trapping subtract trapped");
  trap_only_sub_a: assert property (rsp.ovfTrap |-> $past(op) == csu_pkg::CSU_OP_SUB)
    else $error("trap from wrong operation");
endmodule : csu_unit
`default_nettype wire

// ==== testbench/csu_rf_model.sv ====
// register file model that takes the write-backs of the compare, shift and subtract unit
`default_nettype none
module csu_rf_model (
  input wire logic core_clk, // core clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire csu_pkg::csu_rsp_t rsp, // write-back from the unit
  input wire logic [4:0] rdAddr, // read index
  output logic [63:0] rdData // read value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] regs [32];
  // write port: a trapped subtract comes without wrEn, so the entry keeps its old value
  always @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= 64'h0;
      end
    end else if (rsp.wrEn && rsp.wrAddr != 5'h00) begin
      regs[rsp.wrAddr] <= rsp.wrData;
    end
  end
  // index zero is never written, so it reads as zero
  assign rdData = regs[rdAddr];
endmodule : csu_rf_model
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking testbench of the compare, shift and subtract unit
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAX_CYCLES = 2000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  csu_pkg::csu_req_t req = '0;
  csu_pkg::csu_rsp_t rsp;
  logic [4:0] rdAddr = 5'h00;
  logic [63:0] rdData;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  always #10 core_clk = ~core_clk;
  csu_unit u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .req(req), .rsp(rsp));
  csu_rf_model u_rf (.core_clk(core_clk), .sys_rst(sys_rst), .rsp(rsp), .rdAddr(rdAddr),
    .rdData(rdData));
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] rf(input logic [4:0] s, t, d, amt, input logic [5:0] fn);
    return {csu_pkg::OPC_REGFMT, s, t, d, amt, fn};
  endfunction : rf
  function automatic logic [31:0] imf(input logic [5:0] op, input logic [15:0] imm);
    return {op, 5'h01, 5'h09, imm};
  endfunction : imf
  // operands and results in 64-bit mode are sign-extended words
  function automatic logic [63:0] sx(input logic [31:0] w);
    return {{32{w[31]}}, w};
  endfunction : sx
  // one request, entered and left at a falling edge; valid stays up for back-to-back use
  task automatic run(input logic [31:0] ins, input logic [63:0] a, b, input logic wr, trap,
                     input logic [4:0] dst, input logic [63:0] exp);
    req.valid = 1'b1;
    req.instr = ins;
    req.srcA = a;
    req.srcB = b;
    @(negedge core_clk);
    chk({63'h0, rsp.done}, 64'h1);
    chk({63'h0, rsp.wrEn}, {63'h0, wr});
    chk({63'h0, rsp.ovfTrap}, {63'h0, trap});
    if (wr) begin
      chk({59'h0, rsp.wrAddr}, {59'h0, dst});
      chk(rsp.wrData, exp);
    end
  endtask : run
  // drop valid; the answer of one cycle must be gone the next
  task automatic idle();
    req.valid = 1'b0;
    @(negedge core_clk);
    chk({63'h0, rsp.done | rsp.wrEn | rsp.ovfTrap}, 64'h0);
  endtask : idle
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_cmp_reg();
    run(rf(1, 2, 3, 0, csu_pkg::FN_LESS_SREG), '1, 64'h1, 1, 0, 3, 64'h1);
    run(rf(1, 2, 4, 0, csu_pkg::FN_LESS_SREG), {1'b0, {63{1'b1}}}, {1'b1, 63'h0}, 1, 0, 4,
        0);
    run(rf(1, 2, 5, 0, csu_pkg::FN_LESS_UREG), 64'h1, '1, 1, 0, 5, 64'h1);
    run(rf(1, 2, 7, 0, csu_pkg::FN_LESS_UREG), '1, 64'h1, 1, 0, 7, 64'h0);
    run(rf(1, 2, 7, 1, csu_pkg::FN_LESS_UREG), 64'h1, '1, 0, 0, 7, 64'h0);
  endtask : t_cmp_reg
  // immediate compares write the second source field, here index 9
  task automatic t_cmp_imm();
    run(imf(csu_pkg::OPC_LESS_SIMM, 16'h8000), 64'hffff_ffff_ffff_0000, 0, 1, 0, 9,
        64'h1);
    run(imf(csu_pkg::OPC_LESS_SIMM, 16'h8000), 64'h0, 0, 1, 0, 9, 64'h0);
    run(imf(csu_pkg::OPC_LESS_SIMM, 16'h0001), {1'b1, 63'h0}, 0, 1, 0, 9, 64'h1);
    run(imf(csu_pkg::OPC_LESS_UIMM, 16'h8000), 64'hffff_ffff_ffff_7fff, 0, 1, 0, 9,
        64'h1);
    run(imf(csu_pkg::OPC_LESS_UIMM, 16'hffff), '1, 0, 1, 0, 9, 64'h0);
  endtask : t_cmp_imm
  // bit 0 of the function picks arithmetic, bit 2 picks the variable amount
  task automatic t_shift();
    logic [5:0] fns [4];
    logic [5:0] fn;
    logic [31:0] w;
    logic [31:0] res;
    fns = '{csu_pkg::FN_SHR_LOGIC_FIX, csu_pkg::FN_SHR_ARITH_FIX, csu_pkg::FN_SHR_LOGIC_VAR,
            csu_pkg::FN_SHR_ARITH_VAR};
    w = 32'h8000_00f0;
    for (int i = 0; i < 4; i++) begin
      fn = fns[i];
      res = fn[0] ? 32'($signed(w) >>> 4) : w >> 4;
      run(rf(fn[2] ? 5'h03 : 5'h00, 5'h04, 5'h05, fn[2] ? 5'h00 : 5'h04, fn),
          fn[2] ? 64'hffff_ffff_ffff_ffe4 : 64'h0, sx(w), 1, 0, 5, sx(res));
    end
    run(rf(0, 4, 5, 0, csu_pkg::FN_SHR_LOGIC_FIX), 0, sx(32'h8000_0000), 1, 0, 5,
        sx(32'h8000_0000));
    run(rf(0, 4, 5, 31, csu_pkg::FN_SHR_ARITH_FIX), 0, sx(32'h4000_0000), 1, 0, 5,
        64'h0);
  endtask : t_shift
  // traps leave index 6 holding the last good difference
  task automatic t_sub();
    run(rf(1, 2, 6, 0, csu_pkg::FN_SUB), sx(32'h5), sx(32'h7), 1, 0, 6, sx(32'hffff_fffe));
    run(rf(1, 2, 6, 0, csu_pkg::FN_SUB), sx(32'h8000_0000), 0, 1, 0, 6, sx(32'h8000_0000));
    run(rf(1, 2, 6, 0, csu_pkg::FN_SUB), sx(32'h8000_0000), sx(32'h1), 0, 1, 6, 0);
    run(rf(1, 2, 6, 0, csu_pkg::FN_SUB), sx(32'h7fff_ffff), '1, 0, 1, 6, 0);
    idle();
    idle();
    rdAddr = 5'h06;
    #1 chk(rdData, sx(32'h8000_0000));
    run(rf(1, 2, 6, 0, csu_pkg::FN_SUBNT), sx(32'h8000_0000), sx(32'h1), 1, 0, 6,
        sx(32'h7fff_ffff));
    run(rf(1, 2, 6, 0, 6'h3f), 0, 0, 0, 0, 6, 0);
  endtask : t_sub
  // ---------------------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // cut a hang short; the whole sequence needs well under a hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == MAX_CYCLES) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    chk({63'h0, rsp.done | rsp.wrEn | rsp.ovfTrap}, 64'h0);
    t_cmp_reg();
    t_cmp_imm();
    t_shift();
    t_sub();
    idle();
    end_sim();
  end
endmodule : tb
`default_nettype wire
